// ### fcsm_clock_select.sv
// module: clock source unit with mode decode, source selection, dividers and avalon registers
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - reset enters loop engaged internal mode
// - system clock from loop, internal or external
// - bus divider two bits, ratios 1/2/4/8
// - system clock output is twice bus clock
// - either reference may steer the loop
// - reference divider uses three-bit select
// - nine-bit writable internal reference trim
// - engaged internal: loop output, internal reference
// - engaged external: loop output, external reference
// - bypassed internal: loop on, internal clock out
// - bypassed internal lowpower: loop off, internal out
// - bypassed external: loop on, external clock out
// - bypassed external lowpower: loop off, external out
// - stop: loop off, no clock, references optional
// - drive external oscillator control outputs
// - source codes 00/01/10, 11 acts as 00
// - bus divider encodes 1..8, resets to two
// - reference divide 2^n, resets to one
// - reference select 0 external, 1 internal
module fcsm_clock_select
   import fcsm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic fllClkIn,
   input wire logic intRefClkIn,
   input wire logic extRefClkIn,
   input wire logic stopReq,
   output logic systemClockOut,
   output logic busClockOut,
   output logic fllRefClockOut,
   output logic fllEnableOut,
   output logic intRefEnableOut,
   output logic extRefRunOut,
   output logic [8:0] intRefTrimOut,
   output logic oscillatorHighGain,
   output logic oscRangeHigh,
   output logic externalReferenceSelect,
   output logic externalReferenceClockEnable,
   output logic externalReferenceStopEnable
);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic [1:0] eff_src(input logic [1:0] code);
      eff_src = (code == 2'h3) ? SRC_FLL : code;
   endfunction : eff_src

   function automatic logic uses_internal(input fcsm_mode_t m);
      uses_internal = (m == LOOP_ENGAGED_INTERNAL) || (m == LOOP_BYPASSED_INTERNAL) ||
                      (m == LOOP_BYPASSED_INTERNAL_LOWPOWER);
   endfunction : uses_internal

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [7:0] ctrl1Reg;
   logic [7:0] ctrl1Next;
   logic [7:0] ctrl2Reg;
   logic [7:0] ctrl2Next;
   logic [8:0] trimReg;
   logic [8:0] trimNext;
   logic waitReg;
   logic waitNext;
   logic [31:0] rdataReg;
   logic [31:0] rdataNext;

   wire logic [1:0] clockSourceField = ctrl1Reg[SRC_FIELD_LSB +: 2];
   wire logic [2:0] referenceDividerField = ctrl1Reg[REFDIV_FIELD_LSB +: 3];
   wire logic internalReferenceSelect = ctrl1Reg[INTREF_SEL_BIT];
   wire logic intRefClockEnable = ctrl1Reg[INTREF_EN_BIT];
   wire logic intRefStopEnable = ctrl1Reg[INTREF_STOPEN_BIT];
   wire logic [1:0] busDividerSelect = ctrl2Reg[BUSDIV_FIELD_LSB +: 2];
   wire logic lowPowerBit = ctrl2Reg[LOWPOWER_BIT];

   // -------------------------------------------------------------
   // avalon slave
   // -------------------------------------------------------------
   // one wait cycle per access: waitrequest drops for exactly one cycle after a request
   wire logic request = avs_read || avs_write;
   wire logic accept = request && !waitReg;
   wire logic writeHit = accept && avs_write;
   wire logic selCtrl1 = (avs_address == OFS_CTRL1);
   wire logic selCtrl2 = (avs_address == OFS_CTRL2);
   wire logic selTrim = (avs_address == OFS_TRIM);
   wire logic selStatus = (avs_address == OFS_STATUS);
   wire logic lane0 = avs_byteenable[0];
   wire logic lane1 = avs_byteenable[1];

   assign waitNext = !(request && waitReg);
   assign ctrl1Next = (writeHit && selCtrl1 && lane0) ? avs_writedata[7:0] : ctrl1Reg;
   assign ctrl2Next = (writeHit && selCtrl2 && lane0) ? avs_writedata[7:0] : ctrl2Reg;
   // trim spans two lanes so each byte lane is honoured on its own
   assign trimNext = {(writeHit && selTrim && lane1) ? avs_writedata[8] : trimReg[8],
                      (writeHit && selTrim && lane0) ? avs_writedata[7:0] : trimReg[7:0]};

   // -------------------------------------------------------------
   // mode decode
   // -------------------------------------------------------------
   fcsm_mode_t runMode;
   fcsm_mode_t activeMode;
   wire logic [1:0] effSource = eff_src(clockSourceField);

   always_comb begin
      unique case (effSource)
         SRC_INTREF: runMode = lowPowerBit ? LOOP_BYPASSED_INTERNAL_LOWPOWER
                                           : LOOP_BYPASSED_INTERNAL;
         SRC_EXTREF: runMode = lowPowerBit ? LOOP_BYPASSED_EXTERNAL_LOWPOWER
                                           : LOOP_BYPASSED_EXTERNAL;
         default: runMode = internalReferenceSelect ? LOOP_ENGAGED_INTERNAL
                                                    : LOOP_ENGAGED_EXTERNAL;
      endcase
   end

   assign activeMode = stopReq ? STOP_MODE : runMode;

   // loop runs in engaged and plain bypassed modes, never in lowpower bypass or stop
   wire logic fllOnNext = (activeMode == LOOP_ENGAGED_INTERNAL) ||
                          (activeMode == LOOP_ENGAGED_EXTERNAL) ||
                          (activeMode == LOOP_BYPASSED_INTERNAL) ||
                          (activeMode == LOOP_BYPASSED_EXTERNAL);
   wire logic intRefNeeded = intRefClockEnable || uses_internal(runMode) ||
                             (fllOnNext && internalReferenceSelect);
   // in stop the internal reference lives on only when its stop enable asks for it
   wire logic intRefOnNext = stopReq ? (intRefStopEnable &&
                                        (intRefClockEnable || uses_internal(runMode)))
                                     : intRefNeeded;
   wire logic extClockEnable = ctrl2Reg[EXTREF_EN_BIT];
   wire logic extStopEnable = ctrl2Reg[EXTREF_STOPEN_BIT];
   wire logic extRefOnNext = stopReq ? (extStopEnable && extClockEnable)
                                     : (extClockEnable || !uses_internal(runMode));

   // -------------------------------------------------------------
   // source input filters
   // -------------------------------------------------------------
   // sources arrive unrelated to clk_sys; a level counts once stages two and three agree
   wire logic [2:0] srcPins = {extRefClkIn, intRefClkIn, fllClkIn};
   logic [2:0] sync1Reg;
   logic [2:0] sync2Reg;
   logic [2:0] sync3Reg;
   logic [2:0] filtReg;
   wire logic [2:0] agree = ~(sync2Reg ^ sync3Reg);
   wire logic [2:0] filtNext = (agree & sync3Reg) | (~agree & filtReg);
   wire logic [2:0] srcToggle = filtNext ^ filtReg;
   wire logic fllToggle = srcToggle[0];
   wire logic intToggle = srcToggle[1];
   wire logic extToggle = srcToggle[2];

   // -------------------------------------------------------------
   // source selection and dividers
   // -------------------------------------------------------------
   // limitation: sources faster than a quarter of clk_sys alias through the filter
   wire logic sysSrcToggle = (effSource == SRC_INTREF) ? intToggle :
                             (effSource == SRC_EXTREF) ? extToggle : fllToggle;
   // either reference, up to 5 MHz, may steer the loop
   wire logic refSrcToggle = internalReferenceSelect ? intToggle : extToggle;

   fcsm_div_if busDivIf();
   fcsm_div_if refDivIf();

   assign busDivIf.srcToggle = sysSrcToggle && !stopReq;
   assign busDivIf.ratioSel = {1'b0, busDividerSelect};
   assign refDivIf.srcToggle = refSrcToggle && fllOnNext;
   // software keeps the divided reference inside the loop's input window
   assign refDivIf.ratioSel = referenceDividerField;

   fcsm_pow2_div u_busDiv (
      .clk_sys(clk_sys),
      .rst(rst),
      .port(busDivIf.divider)
   );

   fcsm_pow2_div u_refDiv (
      .clk_sys(clk_sys),
      .rst(rst),
      .port(refDivIf.divider)
   );

   logic sysClkReg;
   logic busClkReg;
   logic fllRefReg;
   logic fllOnReg;
   logic intRefOnReg;
   logic extRefOnReg;
   wire logic sysClkNext = stopReq ? 1'b0 : busDivIf.outLevel;
   wire logic sysRise = sysClkNext && !sysClkReg;
   // bus clock halves the system clock output
   wire logic busClkNext = sysRise ? !busClkReg : busClkReg;

   // -------------------------------------------------------------
   // read data
   // -------------------------------------------------------------
   wire logic [31:0] statusWord = {27'h0000000, activeMode, effSource};
   assign rdataNext = !(avs_read && waitReg) ? rdataReg :
                      selCtrl1 ? {24'h000000, ctrl1Reg} :
                      selCtrl2 ? {24'h000000, ctrl2Reg} :
                      selTrim ? {23'h000000, trimReg} :
                      selStatus ? statusWord : 32'h00000000;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl1Reg <= CTRL1_RESET;
         ctrl2Reg <= CTRL2_RESET;
         trimReg <= TRIM_RESET;
         waitReg <= 1'b1;
         rdataReg <= 32'h00000000;
      end else begin
         ctrl1Reg <= ctrl1Next;
         ctrl2Reg <= ctrl2Next;
         trimReg <= trimNext;
         waitReg <= waitNext;
         rdataReg <= rdataNext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1Reg <= 3'h0;
         sync2Reg <= 3'h0;
         sync3Reg <= 3'h0;
         filtReg <= 3'h0;
      end else begin
         sync1Reg <= srcPins;
         sync2Reg <= sync1Reg;
         sync3Reg <= sync2Reg;
         filtReg <= filtNext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sysClkReg <= 1'b0;
         busClkReg <= 1'b0;
         fllRefReg <= 1'b0;
         fllOnReg <= 1'b0;
         intRefOnReg <= 1'b0;
         extRefOnReg <= 1'b0;
      end else begin
         sysClkReg <= sysClkNext;
         busClkReg <= busClkNext;
         fllRefReg <= refDivIf.outLevel;
         fllOnReg <= fllOnNext;
         intRefOnReg <= intRefOnNext;
         extRefOnReg <= extRefOnNext;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign avs_readdata = rdataReg;
   assign avs_waitrequest = waitReg;
   assign systemClockOut = sysClkReg;
   assign busClockOut = busClkReg;
   assign fllRefClockOut = fllRefReg;
   assign fllEnableOut = fllOnReg;
   assign intRefEnableOut = intRefOnReg;
   assign extRefRunOut = extRefOnReg;
   assign intRefTrimOut = trimReg;
   assign oscillatorHighGain = ctrl2Reg[HIGHGAIN_BIT];
   assign oscRangeHigh = ctrl2Reg[RANGE_BIT];
   assign externalReferenceSelect = ctrl2Reg[EXTREF_SEL_BIT];
   assign externalReferenceClockEnable = ctrl2Reg[EXTREF_EN_BIT];
   assign externalReferenceStopEnable = ctrl2Reg[EXTREF_STOPEN_BIT];

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence seqRunSteady;
      !stopReq && $stable(ctrl2Reg) && $stable(ctrl1Reg);
   endsequence

   sequence seqDirectSysToggle;
      busDivIf.srcToggle && busDividerSelect == 2'h0 ##1 seqRunSteady;
   endsequence

   AST_RESET_MODE: assert property ($fell(rst) |->
                                    activeMode == LOOP_ENGAGED_INTERNAL || stopReq)
      else $error("mode after reset is not loop engaged internal");

   AST_SYS_DIV_ONE: assert property (seqDirectSysToggle |=> $changed(sysClkReg))
      else $error("system clock did not follow its source at divide by one");

   AST_BUS_HALF: assert property ($rose(sysClkReg) |-> $changed(busClkReg))
      else $error("bus clock failed to toggle on system clock rise");

   AST_BUS_HOLD: assert property (!$rose(sysClkReg) |-> $stable(busClkReg))
      else $error("bus clock moved without a system clock rise");

   AST_LOWPOWER_OFF: assert property (lowPowerBit &&
                                      effSource != SRC_FLL && !stopReq |=> !fllOnReg)
      else $error("loop left enabled in lowpower bypass");

   AST_BYPASS_INT_ON: assert property (activeMode == LOOP_BYPASSED_INTERNAL
                                       |=> fllOnReg && intRefOnReg)
      else $error("bypassed internal mode lost loop or internal reference");

   AST_STOP_NO_CLOCK: assert property (stopReq |=> !sysClkReg && !fllOnReg)
      else $error("clock or loop active in stop");

   AST_STOP_EXT_OFF: assert property (stopReq && !(extStopEnable && extClockEnable)
                                      |=> !extRefRunOut)
      else $error("external reference left running in stop");

   AST_STOP_INT_OFF: assert property (stopReq && !intRefStopEnable |=> !intRefEnableOut)
      else $error("internal reference left running in stop without stop enable");

   AST_WAIT_ONE: assert property (request && waitReg |=> !avs_waitrequest ##1
                                  avs_waitrequest)
      else $error("waitrequest did not pulse low for one cycle");

   AST_TRIM_WRITE: assert property (writeHit && selTrim && lane0 && lane1
                                    |=> intRefTrimOut == $past(avs_writedata[8:0]))
      else $error("trim write not stored");

   AST_SRC_RESERVED: assert property (clockSourceField == 2'h3 && !stopReq |->
                                      activeMode inside {LOOP_ENGAGED_INTERNAL,
                                                         LOOP_ENGAGED_EXTERNAL})
      else $error("reserved source code not treated as loop output");

   // an external edge alone must never clock the loop while the internal one is chosen
   AST_REF_PATH: assert property (internalReferenceSelect && extToggle && !intToggle |->
                                  !refDivIf.srcToggle)
      else $error("loop reference taken from the wrong source");

endmodule : fcsm_clock_select
`default_nettype wire

// ### fcsm_clock_select_test.sv
// testbench: clock source unit registers, clock paths and modes
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end
module fcsm_clock_select_test
   import fcsm_pkg::*;
;
   // --------------------------------------------------------------
   // signals and instances
   // --------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic fllClk, intClk, extClk, stopReq = 1'b0;
   logic systemClockOut, busClockOut, fllRefClockOut, fllEnableOut;
   logic intRefEnableOut, extRefRunOut, oscillatorHighGain, oscRangeHigh;
   logic externalReferenceSelect, externalReferenceClockEnable, externalReferenceStopEnable;
   logic [8:0] intRefTrimOut;
   int failures = 0;
   int n_compared = 0;
   // mode table: control 1, control 2 and system clock period for each mode except stop
   localparam logic [7:0] MC1 [6] = '{8'h00, 8'h44, 8'h44, 8'h80, 8'h80, 8'h04};
   localparam logic [7:0] MC2 [6] = '{8'h40, 8'h40, 8'h48, 8'h40, 8'h48, 8'h40};
   localparam int MPER [6] = '{32, 48, 48, 80, 80, 32};
   localparam int SPER [4] = '{32, 48, 80, 32};

   always #2 clk_sys = ~clk_sys;

   fcsm_src_model u_src (.clk_sys(clk_sys), .fllClk(fllClk), .intClk(intClk), .extClk(extClk));

   fcsm_clock_select u_dut (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fllClkIn(fllClk),
      .intRefClkIn(intClk), .extRefClkIn(extClk), .stopReq(stopReq),
      .systemClockOut(systemClockOut), .busClockOut(busClockOut),
      .fllRefClockOut(fllRefClockOut), .fllEnableOut(fllEnableOut),
      .intRefEnableOut(intRefEnableOut), .extRefRunOut(extRefRunOut),
      .intRefTrimOut(intRefTrimOut), .oscillatorHighGain(oscillatorHighGain),
      .oscRangeHigh(oscRangeHigh), .externalReferenceSelect(externalReferenceSelect),
      .externalReferenceClockEnable(externalReferenceClockEnable),
      .externalReferenceStopEnable(externalReferenceStopEnable));

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   task xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= 4'h3;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i >= 20) begin
         failures++;
         wrap_up();
      end
   endtask : xfer

   task wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, a, {24'h0, d}, q);
      // outputs are registered from the updated register
      repeat (2) @(posedge clk_sys);
   endtask : wr

   task rd(input logic [3:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask : rd

   function automatic logic pick(input int w);
      if (w == 0) return systemClockOut;
      if (w == 1) return busClockOut;
      return fllRefClockOut;
   endfunction : pick

   // period between second and third rise; the first may follow a divider change
   task measure(input int w, output int n);
      int i, k, t;
      logic p, c;
      p = pick(w);
      k = 0;
      t = 0;
      n = 0;
      for (i = 0; i < 16000 && k < 3; i++) begin
         @(posedge clk_sys);
         c = pick(w);
         if (c === 1'b1 && p === 1'b0) begin
            k++;
            if (k == 2) t = i;
            if (k == 3) n = i - t;
         end
         p = c;
      end
      if (k < 3) begin
         failures++;
         wrap_up();
      end
   endtask : measure

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task t_reset;
      logic [31:0] q;
      `CHK(fllEnableOut, 1'b1)
      `CHK(intRefEnableOut, 1'b1)
      `CHK(extRefRunOut, 1'b0)
      rd(OFS_CTRL1, q);
      `CHK(q, 32'h04)
      rd(OFS_CTRL2, q);
      `CHK(q, 32'h40)
      rd(OFS_STATUS, q);
      `CHK(q[4:0], 5'h00)
      rd(4'h2, q);
      `CHK(q, 32'h0)
   endtask : t_reset

   task t_source;
      int s, n;
      logic [31:0] q;
      for (s = 0; s < 4; s++) begin
         wr(OFS_CTRL1, {s[1:0], 6'h04});
         measure(0, n);
         `CHK(n, SPER[s])
         rd(OFS_STATUS, q);
         `CHK(q[1:0], (s == 3) ? 2'h0 : s[1:0])
      end
   endtask : t_source

   task t_busdiv;
      int d, n;
      wr(OFS_CTRL1, 8'h04);
      for (d = 0; d < 4; d++) begin
         wr(OFS_CTRL2, {d[1:0], 6'h00});
         measure(0, n);
         `CHK(n, 16 << d)
         measure(1, n);
         `CHK(n, 32 << d)
      end
      wr(OFS_CTRL2, 8'h40);
   endtask : t_busdiv

   task t_refdiv;
      int r, n;
      for (r = 0; r < 8; r++) begin
         wr(OFS_CTRL1, {2'h0, r[2:0], 3'h4});
         measure(2, n);
         `CHK(n, 24 << r)
      end
      wr(OFS_CTRL1, 8'h08);
      measure(2, n);
      `CHK(n, 80)
   endtask : t_refdiv

   task t_modes;
      int m, n;
      logic [31:0] q;
      for (m = 0; m < 6; m++) begin
         wr(OFS_CTRL1, MC1[m]);
         wr(OFS_CTRL2, MC2[m]);
         rd(OFS_STATUS, q);
         `CHK(q[4:2], (m == 5) ? 3'h0 : 3'(m + 1))
         `CHK(fllEnableOut, (MC2[m] == 8'h40))
         measure(0, n);
         `CHK(n, MPER[m])
      end
   endtask : t_modes

   task t_stop;
      int i;
      logic seen;
      logic [31:0] q;
      wr(OFS_CTRL1, 8'h07);
      wr(OFS_CTRL2, 8'h43);
      stopReq <= 1'b1;
      i = 0;
      do begin
         rd(OFS_STATUS, q);
         i++;
      end while (q[4:2] !== 3'h6 && i < 10);
      `CHK(q[4:2], 3'h6)
      if (q[4:2] !== 3'h6) wrap_up();
      `CHK(fllEnableOut, 1'b0)
      `CHK({intRefEnableOut, extRefRunOut}, 2'b11)
      seen = 1'b0;
      for (i = 0; i < 200; i++) begin
         @(posedge clk_sys);
         seen = seen | (systemClockOut !== 1'b0);
      end
      `CHK(seen, 1'b0)
      wr(OFS_CTRL1, 8'h00);
      wr(OFS_CTRL2, 8'h40);
      `CHK({intRefEnableOut, extRefRunOut}, 2'b00)
      stopReq <= 1'b0;
      wr(OFS_CTRL1, 8'h04);
   endtask : t_stop

   task t_osc;
      logic [31:0] q;
      xfer(1'b1, OFS_TRIM, 32'h1a5, q);
      repeat (2) @(posedge clk_sys);
      `CHK(intRefTrimOut, 9'h1a5)
      rd(OFS_TRIM, q);
      `CHK(q, 32'h1a5)
      wr(OFS_CTRL2, 8'h77);
      `CHK({oscRangeHigh, oscillatorHighGain, externalReferenceSelect,
         externalReferenceClockEnable, externalReferenceStopEnable}, 5'h1f)
      wr(OFS_CTRL2, 8'h40);
      `CHK({oscRangeHigh, oscillatorHighGain, externalReferenceSelect,
         externalReferenceClockEnable, externalReferenceStopEnable}, 5'h00)
   endtask : t_osc

   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_source();
      t_busdiv();
      t_refdiv();
      t_modes();
      t_stop();
      t_osc();
      wrap_up();
   end
endmodule : fcsm_clock_select_test
`default_nettype wire

// ### fcsm_div_if.sv
// interface: link between the clock source unit and one power-of-two divider
`timescale 1ns/1ps
`default_nettype none
interface fcsm_div_if;
   logic srcToggle;
   logic [2:0] ratioSel;
   logic outLevel;
   modport master (output srcToggle, output ratioSel, input outLevel);
   modport divider (input srcToggle, input ratioSel, output outLevel);
endinterface : fcsm_div_if
`default_nettype wire

// ### fcsm_pkg.sv
// package: register map, field positions, reset values and mode type of the clock source unit
package fcsm_pkg;

   // -------------------------------------------------------------
   // register byte offsets on the avalon slave
   // -------------------------------------------------------------
   localparam logic [3:0] OFS_CTRL1 = 4'h0;
   localparam logic [3:0] OFS_CTRL2 = 4'h4;
   localparam logic [3:0] OFS_TRIM = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;

   // -------------------------------------------------------------
   // control 1 fields
   // -------------------------------------------------------------
   localparam int SRC_FIELD_LSB = 6;
   localparam int REFDIV_FIELD_LSB = 3;
   localparam int INTREF_SEL_BIT = 2;
   localparam int INTREF_EN_BIT = 1;
   localparam int INTREF_STOPEN_BIT = 0;

   // -------------------------------------------------------------
   // control 2 fields
   // -------------------------------------------------------------
   localparam int BUSDIV_FIELD_LSB = 6;
   localparam int RANGE_BIT = 5;
   localparam int HIGHGAIN_BIT = 4;
   localparam int LOWPOWER_BIT = 3;
   localparam int EXTREF_SEL_BIT = 2;
   localparam int EXTREF_EN_BIT = 1;
   localparam int EXTREF_STOPEN_BIT = 0;

   // -------------------------------------------------------------
   // status fields
   // -------------------------------------------------------------
   localparam int STATUS_SRC_LSB = 0;
   localparam int STATUS_MODE_LSB = 2;

   // -------------------------------------------------------------
   // clock source codes and reset values
   // -------------------------------------------------------------
   localparam logic [1:0] SRC_FLL = 2'h0;
   localparam logic [1:0] SRC_INTREF = 2'h1;
   localparam logic [1:0] SRC_EXTREF = 2'h2;
   localparam logic [1:0] BUSDIV_RESET = 2'h1;
   localparam logic [2:0] REFDIV_RESET = 3'h0;
   localparam logic [7:0] CTRL1_RESET = 8'h04;
   localparam logic [7:0] CTRL2_RESET = 8'h40;
   // arbitrary mid-scale trim
   localparam logic [8:0] TRIM_RESET = 9'h100;
   localparam int DIV_CNT_W = 7;

   typedef enum logic [2:0] {
      LOOP_ENGAGED_INTERNAL,
      LOOP_ENGAGED_EXTERNAL,
      LOOP_BYPASSED_INTERNAL,
      LOOP_BYPASSED_INTERNAL_LOWPOWER,
      LOOP_BYPASSED_EXTERNAL,
      LOOP_BYPASSED_EXTERNAL_LOWPOWER,
      STOP_MODE
   } fcsm_mode_t;

endpackage : fcsm_pkg

// ### fcsm_pow2_div.sv
// module: divides a stream of source transitions by two to the power of a select
`timescale 1ns/1ps
`default_nettype none
module fcsm_pow2_div
   import fcsm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   fcsm_div_if.divider port
);

   // -------------------------------------------------------------
   // transition counter
   // -------------------------------------------------------------
   function automatic logic [DIV_CNT_W-1:0] ratio_limit(input logic [2:0] sel);
      ratio_limit = (7'h01 << sel) - 7'h01;
   endfunction : ratio_limit

   logic [DIV_CNT_W-1:0] cntReg;
   logic [DIV_CNT_W-1:0] cntNext;
   logic levelReg;
   logic levelNext;
   wire logic atLimit = (cntReg >= ratio_limit(port.ratioSel));

   // compare with >= so a smaller ratio written mid-count does not wrap the counter
   assign cntNext = !port.srcToggle ? cntReg : (atLimit ? 7'h00 : cntReg + 7'h01);
   assign levelNext = (port.srcToggle && atLimit) ? !levelReg : levelReg;
   assign port.outLevel = levelReg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cntReg <= 7'h00;
         levelReg <= 1'b0;
      end else begin
         cntReg <= cntNext;
         levelReg <= levelNext;
      end
   end

   AST_DIV_TOGGLE_AT_LIMIT: assert property (@(posedge clk_sys) disable iff (rst)
      $changed(levelReg) |-> $past(port.srcToggle) && $past(atLimit))
      else $error("divider output toggled before its count was reached");

endmodule : fcsm_pow2_div
`default_nettype wire

// ### fcsm_src_model.sv
// partner model: free-running source clocks that feed the clock source unit
`timescale 1ns/1ps
`default_nettype none
module fcsm_src_model #(
   parameter int FLL_HALF = 8,
   parameter int INT_HALF = 12,
   parameter int EXT_HALF = 20
) (
   input wire logic clk_sys,
   output logic fllClk,
   output logic intClk,
   output logic extClk
);
   // --------------------------------------------------------------
   // sources
   // --------------------------------------------------------------
   // all rates stay far below clk_sys/4 so the sampled path reproduces them exactly
   int unsigned tick = 0;
   always @(posedge clk_sys) begin
      tick <= tick + 1;
      fllClk <= ((tick / FLL_HALF) % 2) == 1;
      intClk <= ((tick / INT_HALF) % 2) == 1;
      extClk <= ((tick / EXT_HALF) % 2) == 1;
   end
endmodule : fcsm_src_model
`default_nettype wire
